//--- src/pack_seq_pkg.sv
package pack_seq_pkg;
    // Register byte addresses
    localparam logic [7:0] CONFIG_ADDR = 8'h00;
    localparam logic [7:0] TIMING_ADDR = 8'h04;
    localparam logic [7:0] SPARE_ADDR  = 8'h08;
    localparam logic [7:0] STATUS_ADDR = 8'h0C;
    localparam logic [7:0] COUNT_ADDR  = 8'h10;

    // Configuration field positions
    localparam int CFG_AUTO        = 0;
    localparam int CFG_START_EMPTY = 1;
    localparam int CFG_THREE_SPEED = 2;
    localparam int CFG_FWC         = 3;
    localparam int CFG_SETTLE      = 4;
    localparam int CFG_RUN_USED    = 5;
    localparam int CFG_INH_USED    = 6;
    localparam int CFG_INT_USED    = 7;
    localparam int CFG_RES_USED    = 8;
    localparam int CFG_W           = 9;

    // Reset values
    localparam logic [CFG_W-1:0] CONFIG_RESET = 9'h00C;
    localparam logic [15:0]      GATE_MS_RESET   = 16'h0064;
    localparam logic [15:0]      SETTLE_MS_RESET = 16'h0032;
    localparam logic [15:0]      SPARE_RESET     = 16'hFFFF;

    // Pin input positions
    localparam int PIN_START     = 0;
    localparam int PIN_DISCHARGE = 1;
    localparam int PIN_GATE_SHUT = 2;
    localparam int PIN_FEED_OPEN = 3;
    localparam int PIN_RESET     = 4;
    localparam int PIN_RUN_EN    = 5;
    localparam int PIN_INHIBIT   = 6;
    localparam int PIN_INTR_N    = 7;
    localparam int PIN_RESUME    = 8;
    localparam int PIN_SPARE1    = 9;
    localparam int PIN_SPARE2    = 10;
    localparam int IN_W          = 11;

    // Logical output count, for spare output selection
    localparam int OUT_W = 10;

    // Timing
    localparam int CLK_HZ        = 250_000_000;
    localparam int MS_PER_SEC    = 1000;
    localparam int MS_CYCLES     = CLK_HZ / MS_PER_SEC;
    localparam logic [7:0] PACK_PULSE_MS = 8'd200;

    typedef enum logic [3:0] {
        S_IDLE     = 4'b0000,
        S_ZERO     = 4'b0001,
        S_WAIT_GATE = 4'b0010,
        S_COARSE   = 4'b0011,
        S_MEDIUM   = 4'b0100,
        S_FINE     = 4'b0101,
        S_SETTLE   = 4'b0110,
        S_CHECK    = 4'b0111,
        S_READY_DIS = 4'b1000,
        S_OPEN     = 4'b1001,
        S_GATE_DLY = 4'b1010,
        S_CLOSE    = 4'b1011,
        S_FAULT    = 4'b1100
    } seq_state_t;
endpackage

//--- src/packing_scale_sequencer.sv
`timescale 1ns/10ps
// How it works
// - Fill and empty cycles alternate, automatically or from fill-start and discharge pins.
// - In automatic mode a config bit picks filling or emptying as first phase.
// - A new fill starts after emptying while the start input is high in automatic mode, or else on its rising edge.
// - The scale is zeroed before any feeding begins.
// - Two- or three-speed feeding begins only while the discharge gate reads closed.
// - At the end of feeding the weight is checked against tolerance.
// - Fill-complete is asserted only when the tolerance check passes.
// - After a good fill, ready-to-discharge tells the packer it may empty.
// - An accepted discharge request opens the discharge gate.
// - When load falls below empty weight the gate delay timer starts.
// - Gate delay expiry closes the gate and pulses pack-filled for 200 ms.
// - Once the gate reads closed again the scale returns to ready-to-fill.
// - Fine feed runs with coarse, or only after coarse, per config bit.
// - A settling delay follows filling only when cut-off correction is after filling.
// - Run-permit, fill-inhibit and resume inputs are active high.
// - A start is executed only while run-permit is high.
// - The interrupt input is active low and suspends filling while low.
// - Discharge gate closed feedback is taken, feed-open is not; discharge and feed gate outputs are separate.
// - Spare input and output pins can take over the function of a failed pin.
module packing_scale_sequencer #(
    parameter int TICK_CYCLES = pack_seq_pkg::MS_CYCLES
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic [7:0]                    paddr,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [pack_seq_pkg::IN_W-1:0] pin_in,
    input  wire logic                          zero_done,
    input  wire logic                          coarse_cut,
    input  wire logic                          medium_cut,
    input  wire logic                          fine_cut,
    input  wire logic                          in_tolerance,
    input  wire logic                          below_empty,
    output logic                               zero_req,
    output logic                               ready_fill,
    output logic                               coarse_feed,
    output logic                               medium_feed,
    output logic                               fine_feed,
    output logic                               open_dis_gate,
    output logic                               open_feed_gate,
    output logic                               ready_dis,
    output logic                               pack_filled,
    output logic                               fill_complete,
    output logic                               error_out,
    output logic      [1:0]                    spare_out
);
    import pack_seq_pkg::*;

    localparam int TICK_W = $clog2(TICK_CYCLES + 1);

    if (TICK_CYCLES < 1) begin : g_tick_check
        $error("TICK_CYCLES must be at least 1");
    end

    // Pick one logical output by index; out-of-range index gives zero
    function automatic logic pick_out(input logic [OUT_W-1:0] vec, input logic [3:0] sel);
        logic res;
        res = 1'b0;
        for (int k = 0; k < OUT_W; k++) begin
            if (sel == 4'(k)) begin
                res = vec[k];
            end
        end
        return res;
    endfunction

    logic [IN_W-1:0]   sync1_reg;
    logic [IN_W-1:0]   sync2_reg;
    logic [IN_W-1:0]   in_eff;
    logic [IN_W-1:0]   prev_reg;
    logic [CFG_W-1:0]  config_reg;
    logic [15:0]       gate_ms_reg;
    logic [15:0]       settle_ms_reg;
    logic [15:0]       spare_reg;
    logic [15:0]       pack_count_reg;
    seq_state_t        state_reg;
    seq_state_t        state_next;
    logic [TICK_W-1:0] tick_cnt_reg;
    logic              tick;
    logic [15:0]       timer_reg;
    logic [7:0]        pulse_reg;
    logic              suspend_reg;
    logic              first_reg;
    logic              tol_ok_reg;
    logic              run_ok;
    logic              go;
    logic              suspend_cond;
    logic              start_rise;
    logic              dis_rise;
    logic              reset_rise;
    logic [OUT_W-1:0]  out_vec;
    logic              apb_write;
    logic              apb_read;

    // Two-stage synchronisers for all pins
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
        end
    end

    // Spare pins replace a failed input when mapped onto it
    always_comb begin
        in_eff = sync2_reg;
        for (int k = 0; k < PIN_SPARE1; k++) begin
            if (spare_reg[3:0] == 4'(k)) begin
                in_eff[k] = sync2_reg[PIN_SPARE1];
            end
            if (spare_reg[7:4] == 4'(k)) begin
                in_eff[k] = sync2_reg[PIN_SPARE2];
            end
        end
    end

    // Previous values for edge detection
    always_ff @(posedge clk) begin
        if (rst) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= in_eff;
        end
    end

    assign start_rise = in_eff[PIN_START] & ~prev_reg[PIN_START];
    assign dis_rise   = in_eff[PIN_DISCHARGE] & ~prev_reg[PIN_DISCHARGE];
    assign reset_rise = in_eff[PIN_RESET] & ~prev_reg[PIN_RESET];

    // Start qualification: run permit active high, level start in automatic mode
    assign run_ok = ~config_reg[CFG_RUN_USED] | in_eff[PIN_RUN_EN];
    assign go = run_ok & (config_reg[CFG_AUTO] ? in_eff[PIN_START] : start_rise);

    // Inhibit is active high, interrupt active low
    assign suspend_cond = (config_reg[CFG_INH_USED] & in_eff[PIN_INHIBIT])
                        | (config_reg[CFG_INT_USED] & ~in_eff[PIN_INTR_N]);

    // Suspension latch; with resume in use it waits for resume high to clear
    always_ff @(posedge clk) begin
        if (rst) begin
            suspend_reg <= 1'b0;
        end else if (suspend_cond) begin
            suspend_reg <= 1'b1;
        end else if (~config_reg[CFG_RES_USED] | in_eff[PIN_RESUME]) begin
            suspend_reg <= 1'b0;
        end
    end

    // Millisecond tick divider
    always_ff @(posedge clk) begin
        if (rst || tick) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + TICK_W'(1);
        end
    end

    assign tick = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));

    // Sequence state decisions
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE: begin
                if (go) begin
                    if (first_reg && config_reg[CFG_AUTO] && config_reg[CFG_START_EMPTY]) begin
                        state_next = S_READY_DIS;
                    end else begin
                        state_next = S_ZERO;
                    end
                end
            end
            S_ZERO: begin
                if (zero_done) begin
                    state_next = S_WAIT_GATE;
                end
            end
            S_WAIT_GATE: begin
                if (in_eff[PIN_GATE_SHUT]) begin
                    state_next = S_COARSE;
                end
            end
            S_COARSE: begin
                if (!suspend_reg && coarse_cut) begin
                    state_next = config_reg[CFG_THREE_SPEED] ? S_MEDIUM : S_FINE;
                end
            end
            S_MEDIUM: begin
                if (!suspend_reg && medium_cut) begin
                    state_next = S_FINE;
                end
            end
            S_FINE: begin
                if (!suspend_reg && fine_cut) begin
                    state_next = config_reg[CFG_SETTLE] ? S_SETTLE : S_CHECK;
                end
            end
            S_SETTLE: begin
                if (timer_reg == 16'h0000) begin
                    state_next = S_CHECK;
                end
            end
            S_CHECK: begin
                state_next = in_tolerance ? S_READY_DIS : S_FAULT;
            end
            S_READY_DIS: begin
                if (dis_rise) begin
                    state_next = S_OPEN;
                end
            end
            S_OPEN: begin
                if (below_empty) begin
                    state_next = S_GATE_DLY;
                end
            end
            S_GATE_DLY: begin
                if (timer_reg == 16'h0000) begin
                    state_next = S_CLOSE;
                end
            end
            S_CLOSE: begin
                if (in_eff[PIN_GATE_SHUT]) begin
                    state_next = S_IDLE;
                end
            end
            S_FAULT: begin
                state_next = S_FAULT;
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
        if (reset_rise) begin
            state_next = S_IDLE;
        end
    end

    // State register and first-cycle flag
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= S_IDLE;
            first_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            if (state_reg == S_IDLE && state_next != S_IDLE) begin
                first_reg <= 1'b0;
            end
        end
    end

    // Millisecond delay timer, loaded on entry to a timed state
    always_ff @(posedge clk) begin
        if (rst) begin
            timer_reg <= '0;
        end else if (state_next == S_SETTLE && state_reg != S_SETTLE) begin
            timer_reg <= settle_ms_reg;
        end else if (state_next == S_GATE_DLY && state_reg != S_GATE_DLY) begin
            timer_reg <= gate_ms_reg;
        end else if (tick && timer_reg != 16'h0000) begin
            timer_reg <= timer_reg - 16'h0001;
        end
    end

    // Pack-filled pulse length counter
    always_ff @(posedge clk) begin
        if (rst) begin
            pulse_reg <= '0;
        end else if (state_reg == S_GATE_DLY && state_next == S_CLOSE) begin
            pulse_reg <= PACK_PULSE_MS;
        end else if (tick && pulse_reg != 8'h00) begin
            pulse_reg <= pulse_reg - 8'h01;
        end
    end

    // Tolerance pass flag, held while offering the charge
    always_ff @(posedge clk) begin
        if (rst) begin
            tol_ok_reg <= 1'b0;
        end else if (state_reg == S_CHECK) begin
            tol_ok_reg <= in_tolerance;
        end else if (state_reg != S_READY_DIS) begin
            tol_ok_reg <= 1'b0;
        end
    end

    // Completed pack counter, cleared by writing its register
    always_ff @(posedge clk) begin
        if (rst || (apb_write && paddr == COUNT_ADDR)) begin
            pack_count_reg <= '0;
        end else if (state_reg == S_GATE_DLY && state_next == S_CLOSE) begin
            pack_count_reg <= pack_count_reg + 16'h0001;
        end
    end

    // Registered machine outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            zero_req       <= 1'b0;
            ready_fill     <= 1'b0;
            coarse_feed    <= 1'b0;
            medium_feed    <= 1'b0;
            fine_feed      <= 1'b0;
            open_dis_gate  <= 1'b0;
            open_feed_gate <= 1'b0;
            ready_dis      <= 1'b0;
            pack_filled    <= 1'b0;
            fill_complete  <= 1'b0;
            error_out      <= 1'b0;
        end else begin
            zero_req       <= (state_reg == S_ZERO);
            ready_fill     <= (state_reg == S_IDLE);
            coarse_feed    <= (state_reg == S_COARSE) && !suspend_reg && !open_dis_gate;
            medium_feed    <= (state_reg == S_MEDIUM) && !suspend_reg && !open_dis_gate;
            fine_feed      <= ((state_reg == S_FINE)
                              || (config_reg[CFG_FWC]
                                  && (state_reg == S_COARSE || state_reg == S_MEDIUM)))
                              && !suspend_reg && !open_dis_gate;
            open_dis_gate  <= (state_reg == S_OPEN || state_reg == S_GATE_DLY);
            open_feed_gate <= (state_reg >= S_COARSE && state_reg <= S_FINE)
                              && !suspend_reg;
            ready_dis      <= (state_reg == S_READY_DIS);
            pack_filled    <= (pulse_reg != 8'h00);
            fill_complete  <= tol_ok_reg && (state_reg == S_READY_DIS);
            error_out      <= (state_reg == S_FAULT);
        end
    end

    // Logical output vector offered to the spare output pins
    assign out_vec = {error_out, fill_complete, pack_filled, ready_dis, open_feed_gate,
                      open_dis_gate, fine_feed, medium_feed, coarse_feed, ready_fill};

    // Spare output pins mirror a selected logical output
    always_ff @(posedge clk) begin
        if (rst) begin
            spare_out <= 2'b00;
        end else begin
            spare_out[0] <= pick_out(out_vec, spare_reg[11:8]);
            spare_out[1] <= pick_out(out_vec, spare_reg[15:12]);
        end
    end

    // APB slave: one wait state, then pready for one cycle
    assign apb_write = psel && penable && pready && pwrite;
    assign apb_read  = psel && penable && !pready && !pwrite;

    always_ff @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    // Software-written registers
    always_ff @(posedge clk) begin
        if (rst) begin
            config_reg    <= CONFIG_RESET;
            gate_ms_reg   <= GATE_MS_RESET;
            settle_ms_reg <= SETTLE_MS_RESET;
            spare_reg     <= SPARE_RESET;
        end else if (apb_write) begin
            case (paddr)
                CONFIG_ADDR: config_reg <= pwdata[CFG_W-1:0];
                TIMING_ADDR: begin
                    gate_ms_reg   <= pwdata[15:0];
                    settle_ms_reg <= pwdata[31:16];
                end
                SPARE_ADDR: spare_reg <= pwdata[15:0];
                default: begin
                end
            endcase
        end
    end

    // Read data and error answer, presented with pready
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            prdata  <= '0;
            pslverr <= 1'b0;
            case (paddr)
                CONFIG_ADDR: prdata <= {{(32 - CFG_W){1'b0}}, config_reg};
                TIMING_ADDR: prdata <= {settle_ms_reg, gate_ms_reg};
                SPARE_ADDR:  prdata <= {16'h0000, spare_reg};
                STATUS_ADDR: begin
                    if (apb_read) begin
                        prdata <= {10'h000, tol_ok_reg, suspend_reg, 1'b0, in_eff,
                                   3'b000, 1'b0, state_reg};
                    end else begin
                        pslverr <= 1'b1;
                    end
                end
                COUNT_ADDR:  prdata <= {16'h0000, pack_count_reg};
                default:     pslverr <= 1'b1;
            endcase
        end else begin
            pslverr <= 1'b0;
        end
    end
endmodule

//--- sim/pss_checker_sva.sv
`timescale 1ns/10ps
module pss_checker #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic                          clk,
    input wire logic                          rst,
    input wire logic                          psel,
    input wire logic                          penable,
    input wire logic                          pready,
    input wire logic                          pslverr,
    input wire logic [pack_seq_pkg::IN_W-1:0] pin_in,
    input wire logic                          zero_req,
    input wire logic                          ready_fill,
    input wire logic                          coarse_feed,
    input wire logic                          medium_feed,
    input wire logic                          fine_feed,
    input wire logic                          open_dis_gate,
    input wire logic                          ready_dis,
    input wire logic                          pack_filled,
    input wire logic                          fill_complete,
    input wire logic                          error_out
);
    import pack_seq_pkg::*;
    localparam int PK_MIN = 199 * TICK_CYCLES;
    localparam int PK_MAX = 201 * TICK_CYCLES;
    logic [31:0] pk_cnt;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Length of the current pack-filled pulse
    always_ff @(posedge clk) begin
        if (rst || !pack_filled)
            pk_cnt <= '0;
        else
            pk_cnt <= pk_cnt + 1;
    end

    // Bus answers with one wait state, one cycle wide
    a_pready_wait: assert property ($rose(penable) && psel |=> pready)
        else $error("pready not one cycle after access");
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready wider than one cycle");
    a_err_in_access: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr outside an answered access");
    // Sequencing relations
    a_feeds_off_open: assert property (open_dis_gate |-> !(coarse_feed || medium_feed || fine_feed))
        else $error("feed active with discharge gate open");
    a_open_cause: assert property ($rose(open_dis_gate) |-> $past(ready_dis))
        else $error("gate opened without ready to discharge");
    a_cpl_needs_ok: assert property (fill_complete |-> ready_dis && !error_out)
        else $error("fill complete without good fill");
    a_feed_gate_shut: assert property ($rose(coarse_feed) |-> $past(pin_in[PIN_GATE_SHUT], 4))
        else $error("feeding began with gate not closed");
    a_zero_first: assert property ($fell(ready_fill) |-> zero_req)
        else $error("left ready state without zeroing");
    a_close_pulse: assert property ($fell(open_dis_gate) |-> pack_filled)
        else $error("gate closed without pack filled pulse");
    a_pack_len: assert property ($fell(pack_filled) |-> pk_cnt >= PK_MIN && pk_cnt <= PK_MAX)
        else $error("pack filled pulse length wrong");
    a_back_to_ready: assert property ($fell(open_dis_gate) |-> ##[1:1000] ready_fill)
        else $error("no return to ready to fill");
endmodule

bind packing_scale_sequencer pss_checker #(.TICK_CYCLES(TICK_CYCLES)) pss_checker_i (
    .clk, .rst, .psel, .penable, .pready, .pslverr, .pin_in, .zero_req, .ready_fill,
    .coarse_feed, .medium_feed, .fine_feed, .open_dis_gate, .ready_dis, .pack_filled,
    .fill_complete, .error_out);

//--- sim/plc_model.sv
`timescale 1ns/10ps
module plc_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic rogue,
    input wire logic ready_dis,
    input wire logic open_dis_gate,
    input wire logic open_feed_gate,
    output logic     discharge,
    output logic     gate_shut,
    output logic     feed_open
);
    logic [4:0] wait_reg;

    // Gate feedback follows the gate commands one cycle late
    always_ff @(posedge clk) begin
        gate_shut <= rst || !open_dis_gate;
        feed_open <= !rst && open_feed_gate;
    end

    // Discharge asked once material and pack are ready, promptly or late; with rogue set it is also asked while not ready
    always_ff @(posedge clk) begin
        if (rst || !ready_dis) begin
            wait_reg  <= slow ? 5'h14 : 5'h01;
            discharge <= rogue;
        end else if (wait_reg != 5'h00) begin
            wait_reg <= wait_reg - 5'h01;
        end else begin
            discharge <= 1'b1;
        end
    end
endmodule

//--- sim/tb_packing_scale_sequencer.sv
`timescale 1ns/10ps
module tb_packing_scale_sequencer;
    import pack_seq_pkg::*;
    localparam int TICK = 4;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, seed, cfg;
    logic pready, pslverr, zero_req, ready_fill, coarse_feed, medium_feed, fine_feed;
    logic open_dis_gate, open_feed_gate, ready_dis, pack_filled, fill_complete, error_out;
    logic zero_done = 0, coarse_cut = 0, medium_cut = 0, fine_cut = 0, below_empty = 0;
    logic in_tolerance = 0, start = 0, rst_pin = 0, run_en = 0, intr_n = 1, hold = 0;
    logic slow = 0, rogue = 0, discharge, gate_shut, feed_open, seen = 0, ok;
    logic [1:0] spare_out;
    logic [10:0] pin_in;
    logic [33:0] ent, rd_q[$];
    logic ev_q[$];
    int n_mismatch = 0, comparisons = 0, passes = 0;

    assign pin_in = {3'b000, intr_n, 1'b0, run_en, rst_pin, feed_open, gate_shut, discharge, start};

    always #2 clk = ~clk;

    packing_scale_sequencer #(.TICK_CYCLES(TICK)) packing_scale_sequencer_i (
        .clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .pin_in, .zero_done, .coarse_cut, .medium_cut, .fine_cut, .in_tolerance, .below_empty,
        .zero_req, .ready_fill, .coarse_feed, .medium_feed, .fine_feed, .open_dis_gate,
        .open_feed_gate, .ready_dis, .pack_filled, .fill_complete, .error_out, .spare_out);

    plc_model plc_model_i (.clk, .rst, .slow, .rogue, .ready_dis, .open_dis_gate,
        .open_feed_gate, .discharge, .gate_shut, .feed_open);

    // Weighing side answers each phase a cycle later
    always @(posedge clk) begin
        zero_done   <= zero_req;
        coarse_cut  <= coarse_feed & !hold;
        medium_cut  <= medium_feed;
        fine_cut    <= fine_feed & !coarse_feed & !medium_feed;
        below_empty <= open_dis_gate;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One APB transfer; e holds {check data, error, data}
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       input logic [33:0] e);
        rd_q.push_back(e);
        psel    <= 1'b1;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // One fill and, when good, its discharge
    task automatic fill(input logic pass, input logic pause, input logic fwc);
        ev_q.push_back(pass);
        in_tolerance <= pass;
        hold         <= pause;
        start        <= 1'b1;
        repeat (2) @(posedge clk);
        start <= 1'b0;
        for (int i = 0; i < 200 && coarse_feed !== 1'b1; i++) @(negedge clk);
        chk("fine_feed", 32'(fwc), 32'(fine_feed));
        @(posedge clk);
        if (pause) begin
            intr_n <= 1'b0;
            repeat (6) @(posedge clk);
            @(negedge clk);
            chk("coarse_feed", 32'h0, 32'(coarse_feed));
            @(posedge clk);
            intr_n <= 1'b1;
            hold   <= 1'b0;
        end
        if (!pass) begin
            for (int i = 0; i < 300 && error_out !== 1'b1; i++) @(posedge clk);
            rst_pin <= 1'b1;
            repeat (4) @(posedge clk);
            rst_pin <= 1'b0;
        end
        for (int i = 0; i < 3000 && ready_fill !== 1'b1; i++) @(posedge clk);
        chk("ready_fill", 32'h1, 32'(ready_fill));
        chk("pack_filled", 32'(pass), 32'(pack_filled));
        for (int i = 0; i < 900 && pack_filled !== 1'b0; i++) @(posedge clk);
        @(posedge clk);
    endtask

    // Results are compared as they appear
    always @(negedge clk) begin
        if (pready === 1'b1 && rd_q.size() > 0) begin
            ent = rd_q.pop_front();
            chk("pslverr", 32'(ent[32]), 32'(pslverr));
            if (ent[33])
                chk("prdata", ent[31:0], prdata);
        end
        if ((ready_dis | error_out) === 1'b1 && !seen && ev_q.size() > 0) begin
            ok = ev_q.pop_front();
            chk("ready_dis", 32'(ok), 32'(ready_dis));
            chk("fill_complete", 32'(ok), 32'(fill_complete));
        end
        seen = (ready_dis | error_out) === 1'b1;
    end

    // Main sequence
    initial begin
        seed = 32'hB510;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(CONFIG_ADDR, 1'b0, 32'h0, {2'b10, 23'h0, CONFIG_RESET});
        apb(TIMING_ADDR, 1'b0, 32'h0, {2'b10, SETTLE_MS_RESET, GATE_MS_RESET});
        apb(SPARE_ADDR, 1'b0, 32'h0, {2'b10, 16'h0, SPARE_RESET});
        apb(COUNT_ADDR, 1'b0, 32'h0, {2'b10, 32'h0});
        apb(8'h14, 1'b0, 32'h0, {2'b11, 32'h0});
        apb(STATUS_ADDR, 1'b1, 32'h5, {2'b01, 32'h0});
        $display("test registers done");
        rogue <= 1'b1;
        repeat (10) @(posedge clk);
        rogue <= 1'b0;
        @(negedge clk);
        chk("open_dis_gate", 32'h0, 32'(open_dis_gate));
        @(posedge clk);
        apb(TIMING_ADDR, 1'b1, 32'h0002_0003, {2'b00, 32'h0});
        run_en <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            seed = lfsr(seed);
            cfg  = (seed & 32'h1C) | 32'hA0;
            apb(CONFIG_ADDR, 1'b1, cfg, {2'b00, 32'h0});
            apb(CONFIG_ADDR, 1'b0, 32'h0, {2'b10, cfg});
            slow <= k[0];
            fill(k != 3, k == 1, cfg[CFG_FWC]);
            if (k != 3)
                passes++;
            $display("test fill %0d done", k);
        end
        apb(COUNT_ADDR, 1'b0, 32'h0, {2'b10, 32'(passes)});
        repeat (4) @(posedge clk);
        close_out();
    end

    // Watchdog
    initial begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        close_out();
    end
endmodule
